// ===== bench/psmrs_core_assertions.sv
// port checks for the program space map and return stack core
// assumes the config byte only moves while reset is high
`timescale 1ns/1ps
`default_nettype none
module psmrs_core_assertions
  import psmrs_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic [7:0] i_program_space_config_byte,
  input wire logic i_push,
  input wire logic i_pop,
  input wire logic i_irq_ack,
  input wire logic i_irq_high,
  input wire logic i_acc_req,
  input wire logic i_acc_write,
  input wire logic [20:0] i_acc_addr,
  input wire logic i_reg_rd,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_pc_load,
  input wire logic [20:0] o_pc_target,
  input wire logic o_int_req,
  input wire logic o_ext_req,
  input wire logic [20:0] o_mem_addr,
  input wire logic [1:0] o_wait_count,
  input wire logic o_rdata_valid,
  input wire logic [15:0] o_rdata
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  // ----------------------------------------------------------------
  // access steps
  // ----------------------------------------------------------------
  sequence high_read_s;
    i_acc_req && !i_acc_write && i_program_space_config_byte[1:0] == 2'b11 && i_acc_addr > FLASH_TOP_32K;
  endsequence
  sequence zero_answer_s;
    !o_int_req && !o_ext_req ##1 o_rdata_valid && o_rdata == 16'h0000;
  endsequence

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  boot_start_a: assert property ($fell(i_reset) |=> o_pc_load && o_pc_target == 21'h000000)
    else $error("no boot load after reset");
  high_zero_a: assert property (high_read_s |=> zero_answer_s)
    else $error("read above flash not zero");
  route_excl_a: assert property (!(o_int_req && o_ext_req))
    else $error("both memories requested");
  ext_only_a: assert property (i_acc_req && i_program_space_config_byte[1:0] == 2'b10
    |=> o_ext_req && !o_int_req)
    else $error("external mode access not external");
  boot_ext_a: assert property (i_acc_req && i_program_space_config_byte[1:0] == 2'b01
    && i_acc_addr > BOOT_TOP_SMALL |=> o_ext_req)
    else $error("boot mode high access not external");
  int_no_bus_a: assert property (i_program_space_config_byte[1:0] == 2'b11 |-> !o_ext_req)
    else $error("internal mode used bus");
  addr_pass_a: assert property (i_acc_req |=> o_mem_addr == $past(i_acc_addr))
    else $error("access address lost");
  irq_vector_a: assert property (i_irq_ack |=> o_pc_load
    && o_pc_target == ($past(i_irq_high) ? 21'h000008 : 21'h000018))
    else $error("wrong interrupt vector");
  pop_load_a: assert property (i_pop && !i_push && !i_irq_ack |=> o_pc_load)
    else $error("pop gave no counter load");
  wait_off_a: assert property (i_program_space_config_byte[7] |-> o_wait_count == 2'h0)
    else $error("waits while disabled");
  reg_idle_a: assert property (!i_reg_rd |=> o_reg_rdata == 8'h00)
    else $error("read data without read");
endmodule
`default_nettype wire

// ===== bench/psmrs_mem_model.sv
// flash and external program memory as seen by the core
// assumes requests are one-cycle pulses beside a stable address
`timescale 1ns/1ps
`default_nettype none
module psmrs_mem_model (
  input wire logic i_core_clk,
  input wire logic i_int_req,
  input wire logic i_ext_req,
  input wire logic [20:0] i_addr,
  output logic [15:0] o_int_rdata,
  output logic [15:0] o_ext_rdata
);
  logic [15:0] junk_ff = 16'h5a5a;

  // junk toggles so stale data never passes for an answer
  always_ff @(posedge i_core_clk)
    junk_ff <= ~junk_ff;

  // two separate buses, each answers only in its request cycle
  assign o_int_rdata = i_int_req ? (i_addr[15:0] ^ 16'h0f0f) : junk_ff;
  assign o_ext_rdata = i_ext_req ? (i_addr[15:0] ^ 16'hf0f0) : ~junk_ff;
endmodule
`default_nettype wire

// ===== bench/tb.sv
// self-checking bench for the program space core
// assumes a 32 Kbyte part with the external bus present
`timescale 1ns/1ps
`default_nettype none
module tb;
  import psmrs_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_por = 1'b1;
  logic [7:0] i_program_space_config_byte = 8'h03;
  logic i_stack_fault_reset_enable = 1'b0;
  logic i_push = 1'b0;
  logic i_pop = 1'b0;
  logic [20:0] i_pc = 21'h0;
  logic i_irq_ack = 1'b0;
  logic i_irq_high = 1'b0;
  logic i_acc_req = 1'b0;
  logic i_acc_write = 1'b0;
  logic [20:0] i_acc_addr = 21'h0;
  logic [15:0] i_int_rdata;
  logic [15:0] i_ext_rdata;
  logic [3:0] i_reg_addr = 4'h0;
  logic [7:0] i_reg_wdata = 8'h00;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [7:0] o_reg_rdata;
  logic o_pc_load;
  logic [20:0] o_pc_target;
  logic o_stack_fault_reset;
  logic o_int_req;
  logic o_ext_req;
  logic o_mem_write;
  logic [20:0] o_mem_addr;
  logic [1:0] o_wait_count;
  logic o_rdata_valid;
  logic [15:0] o_rdata;
  int num_errors = 0;
  int n_compared = 0;
  logic [20:0] addrs [5] = '{21'h000100, 21'h000900, 21'h007ffe, 21'h008000, 21'h1ffffe};

  always #5 i_core_clk = ~i_core_clk;

  psmrs_core psmrs_core_i (.i_core_clk, .i_reset, .i_por, .i_program_space_config_byte,
    .i_stack_fault_reset_enable, .i_push, .i_pop, .i_pc, .i_irq_ack, .i_irq_high, .i_acc_req, .i_acc_write,
    .i_acc_addr, .i_int_rdata, .i_ext_rdata, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata,
    .o_pc_load, .o_pc_target, .o_stack_fault_reset, .o_int_req, .o_ext_req, .o_mem_write, .o_mem_addr,
    .o_wait_count, .o_rdata_valid, .o_rdata);
  psmrs_mem_model psmrs_mem_model_i (.i_core_clk, .i_int_req(o_int_req), .i_ext_req(o_ext_req),
    .i_addr(o_mem_addr), .o_int_rdata(i_int_rdata), .o_ext_rdata(i_ext_rdata));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tick;
    @(posedge i_core_clk);
  endtask
  task automatic do_reset(input logic [7:0] c, input logic opt, input logic por);
    tick;
    i_reset <= 1'b1;
    i_program_space_config_byte <= c;
    i_stack_fault_reset_enable <= opt;
    i_por <= por;
    repeat (8) tick;
    i_reset <= 1'b0;
    tick;
    #1 check("boot load", o_pc_load, 1'b1);
    check("boot target", o_pc_target, RESET_VECTOR);
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    tick;
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    tick;
    i_reg_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp);
    tick;
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    tick;
    i_reg_rd <= 1'b0;
    #1 check("reg", o_reg_rdata, exp);
  endtask
  task automatic push(input logic [20:0] pc);
    tick;
    i_push <= 1'b1;
    i_pc <= pc;
    tick;
    i_push <= 1'b0;
  endtask
  task automatic pop(input logic [20:0] exp);
    tick;
    i_pop <= 1'b1;
    tick;
    i_pop <= 1'b0;
    #1 check("pop load", o_pc_load, 1'b1);
    check("pop target", o_pc_target, exp);
  endtask
  task automatic irq(input logic hi, input logic [20:0] pc, input logic [20:0] vec);
    tick;
    i_irq_ack <= 1'b1;
    i_irq_high <= hi;
    i_pc <= pc;
    tick;
    i_irq_ack <= 1'b0;
    #1 check("irq target", o_pc_target, vec);
  endtask
  // route code: 0 zero fill, 1 flash, 2 external
  function automatic logic [1:0] route(input logic [1:0] m, input logic [20:0] a);
    case (m)
      2'b10: return 2'd2;
      2'b11: return (a <= FLASH_TOP_32K) ? 2'd1 : 2'd0;
      2'b01: return (a <= BOOT_TOP_SMALL) ? 2'd1 : 2'd2;
      default: return (a <= FLASH_TOP_32K) ? 2'd1 : 2'd2;
    endcase
  endfunction
  task automatic acc(input logic [20:0] a, input logic w, input logic [1:0] r);
    tick;
    i_acc_req <= 1'b1;
    i_acc_addr <= a;
    i_acc_write <= w;
    tick;
    i_acc_req <= 1'b0;
    #1 check("int req", o_int_req, r == 2'd1);
    check("ext req", o_ext_req, r == 2'd2);
    check("mem write", o_mem_write, w && r != 2'd0);
    tick;
    #1 check("valid", o_rdata_valid, !w);
    if (!w)
      check("data", o_rdata, r == 2'd1 ? a[15:0] ^ 16'h0f0f : r == 2'd2 ? a[15:0] ^ 16'hf0f0 : 16'h0000);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic seen;
    for (int m = 0; m < 4; m++)
    begin
      do_reset({m[0], 5'h00, m[1:0]}, 1'b0, 1'b1);
      reg_wr(REG_MEMORY_BUS_CONTROL, 8'h30);
      repeat (2) tick;
      #1 check("wait", o_wait_count, m[0] ? 2'h0 : 2'h3);
      reg_rd(REG_PROGRAM_SPACE_CONFIG, {m[0], 5'h00, m[1:0]});
      foreach (addrs[k])
        acc(addrs[k], 1'b0, route(m[1:0], addrs[k]));
      acc(21'h008000, 1'b1, route(m[1:0], 21'h008000));
      $display("mode test %0d done", m);
    end
    do_reset(8'h03, 1'b0, 1'b1);
    reg_rd(REG_RETURN_STACK_POINTER, 8'h00);
    push(21'h012345);
    push(21'h0abcde);
    reg_rd(REG_RETURN_STACK_POINTER, 8'h02);
    reg_rd(REG_STACK_TOP_LOW, 8'hde);
    reg_rd(REG_STACK_TOP_HIGH, 8'hbc);
    reg_rd(REG_STACK_TOP_UPPER, 8'h0a);
    // interrupts stay quiet while the top is edited
    reg_wr(REG_STACK_TOP_LOW, 8'h11);
    reg_wr(REG_STACK_TOP_HIGH, 8'h22);
    reg_wr(REG_STACK_TOP_UPPER, 8'hff);
    reg_rd(REG_STACK_TOP_UPPER, 8'h1f);
    pop(21'h1f2211);
    pop(21'h012345);
    pop(21'h000000);
    reg_rd(REG_RETURN_STACK_POINTER, 8'h40);
    do_reset(8'h03, 1'b0, 1'b0);
    reg_rd(REG_RETURN_STACK_POINTER, 8'h40);
    reg_wr(REG_RETURN_STACK_POINTER, 8'h00);
    reg_rd(REG_RETURN_STACK_POINTER, 8'h00);
    $display("stack basic test done");
    irq(1'b1, 21'h000456, IRQ_HIGH_VECTOR);
    irq(1'b0, 21'h000500, IRQ_LOW_VECTOR);
    reg_rd(REG_RETURN_STACK_POINTER, 8'h02);
    pop(21'h000500);
    pop(21'h000456);
    for (int n = 1; n <= 30; n++)
      push(21'(n));
    reg_rd(REG_RETURN_STACK_POINTER, 8'h1e);
    push(21'h0031f0);
    reg_rd(REG_RETURN_STACK_POINTER, 8'h9f);
    push(21'h1eeeee);
    reg_rd(REG_RETURN_STACK_POINTER, 8'h9f);
    pop(21'h0031f0);
    reg_wr(REG_RETURN_STACK_POINTER, 8'h00);
    reg_rd(REG_RETURN_STACK_POINTER, 8'h00);
    reg_wr(4'h9, 8'hff);
    reg_rd(4'h9, 8'h00);
    $display("stack full test done");
    do_reset(8'h03, 1'b1, 1'b1);
    tick;
    i_pop <= 1'b1;
    tick;
    i_pop <= 1'b0;
    #1 seen = o_stack_fault_reset;
    tick;
    #1 seen = seen | o_stack_fault_reset;
    check("fault reset", seen, 1'b1);
    $display("fault test done");
    end_sim;
  end

  // hang guard
  initial
  begin
    repeat (20000) tick;
    num_errors++;
    end_sim;
  end
endmodule

bind psmrs_core psmrs_core_assertions psmrs_core_assertions_i (.i_core_clk, .i_reset, .i_program_space_config_byte,
  .i_push, .i_pop, .i_irq_ack, .i_irq_high, .i_acc_req, .i_acc_write, .i_acc_addr, .i_reg_rd, .o_reg_rdata,
  .o_pc_load, .o_pc_target, .o_int_req, .o_ext_req, .o_mem_addr, .o_wait_count, .o_rdata_valid, .o_rdata);
`default_nettype wire

// ===== design/psmrs_addr_map.sv
// address router: decides where one program space access goes
// assumes mode and limits are stable, sampled at reset by the parent
`timescale 1ns/1ps
`default_nettype none
module psmrs_addr_map
  import psmrs_pkg::*;
(
  input wire logic [1:0] i_mode,
  input wire logic [20:0] i_addr,
  input wire logic [20:0] i_flash_top,
  input wire logic [20:0] i_boot_top,
  output logic o_to_int,
  output logic o_to_ext,
  output logic o_zero_fill
);

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  // every 21-bit address lands somewhere: flash, external or zero
  always_comb
  begin
    o_to_int = 1'b0;
    o_to_ext = 1'b0;
    o_zero_fill = 1'b0;
    case (i_mode)
      PSMRS_EXTERNAL_ONLY_MODE:
      begin
        o_to_ext = 1'b1;
      end
      PSMRS_BOOT_BLOCK_EXTERNAL_MODE:
      begin
        o_to_int = (i_addr <= i_boot_top);
        o_to_ext = (i_addr > i_boot_top);
      end
      PSMRS_INTERNAL_ONLY_MODE:
      begin
        o_to_int = (i_addr <= i_flash_top);
        o_zero_fill = (i_addr > i_flash_top);
      end
      default:
      begin
        o_to_int = (i_addr <= i_flash_top);
        o_to_ext = (i_addr > i_flash_top);
      end
    endcase
  end

endmodule
`default_nettype wire

// ===== design/psmrs_core.sv
// program space map and hardware return address stack
// assumes the sequencer issues one-cycle push/pop strobes and that
// program memories answer a request in the same cycle it stands
//
// Operation
// - 21-bit byte space, unimplemented reads give zero
// - start at 0000h, vectors 0008h and 0018h
// - two-bit setting picks one of four modes
// - external-only mode routes everything off chip
// - boot block low, external above it
// - internal-only never uses bus, zero above flash
// - extended mode: flash bottom, external above
// - data RAM and EEPROM untouched by mode
// - config bit 7 disables or enables bus waits
// - program and data buses are separate
// - calls and interrupts push, returns pop
// - counter latch registers untouched by stack ops
// - 31 entries of 21 bits, 5-bit pointer
// - pointer zero has no entry, empty only
// - push: increment pointer, then write entry
// - pop: read entry, then decrement pointer
// - stack outside memory spaces, software visible
// - three top-of-stack bytes replace selected entry
// - flags show stack at or past capacity
// - interrupt wake pushes pc and vectors
// - full on 31st push, optional fault reset
// - empty pop gives zero, underflow, optional reset
// - flags clear by software zero or power-on
//
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module psmrs_core
  import psmrs_pkg::*;
#(
  parameter int FLASH_KBYTES = 32,
  parameter bit HAS_EXT_BUS = 1'b1
)
(
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_por,
  input wire logic [7:0] i_program_space_config_byte,
  input wire logic i_stack_fault_reset_enable,
  input wire logic i_push,
  input wire logic i_pop,
  input wire logic [20:0] i_pc,
  input wire logic i_irq_ack,
  input wire logic i_irq_high,
  input wire logic i_acc_req,
  input wire logic i_acc_write,
  input wire logic [20:0] i_acc_addr,
  input wire logic [15:0] i_int_rdata,
  input wire logic [15:0] i_ext_rdata,
  input wire logic [3:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  output logic o_pc_load,
  output logic [20:0] o_pc_target,
  output logic o_stack_fault_reset,
  output logic o_int_req,
  output logic o_ext_req,
  output logic o_mem_write,
  output logic [20:0] o_mem_addr,
  output logic [1:0] o_wait_count,
  output logic o_rdata_valid,
  output logic [15:0] o_rdata
);

  // ----------------------------------------------------------------
  // elaboration checks and part limits
  // ----------------------------------------------------------------
  if (FLASH_KBYTES != 32 && FLASH_KBYTES != 64 && FLASH_KBYTES != 128)
  begin : g_bad_size
    $error("FLASH_KBYTES must be 32, 64 or 128");
  end

  localparam logic [20:0] FLASH_TOP = (FLASH_KBYTES == 32) ? FLASH_TOP_32K :
    (FLASH_KBYTES == 64) ? FLASH_TOP_64K : FLASH_TOP_128K;
  // small parts carry a bigger boot block than the larger ones
  localparam logic [20:0] BOOT_TOP = (FLASH_KBYTES == 32) ? BOOT_TOP_SMALL : BOOT_TOP_LARGE;

  // merge one byte of a 21-bit entry, used for all three top bytes
  function automatic logic [20:0] merge_byte(input logic [20:0] old_val,
    input logic [1:0] lane, input logic [7:0] data);
    logic [20:0] res;
    res = old_val;
    case (lane)
      2'd0: res[7:0] = data;
      2'd1: res[15:8] = data;
      default: res[20:16] = data[4:0];
    endcase
    return res;
  endfunction

  // ----------------------------------------------------------------
  // configuration capture
  // ----------------------------------------------------------------
  logic [1:0] cfg_mode_ff;
  logic cfg_wait_dis_ff;
  logic cfg_fault_rst_ff;
  logic [1:0] eff_mode;

  // sampled while reset is held so routing never shifts mid-fetch
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      cfg_mode_ff <= i_program_space_config_byte[1:0];
      cfg_wait_dis_ff <= i_program_space_config_byte[CFG_WAIT_DISABLE_BIT];
      cfg_fault_rst_ff <= i_stack_fault_reset_enable;
    end
  end

  // parts without a bus have only the internal mode
  assign eff_mode = HAS_EXT_BUS ? cfg_mode_ff : PSMRS_INTERNAL_ONLY_MODE;

  // ----------------------------------------------------------------
  // stack control decode
  // ----------------------------------------------------------------
  logic [4:0] sp_ff;
  logic [20:0] stack_ff [1:STACK_DEPTH];
  logic full_ff;
  logic unf_ff;
  logic [7:0] memctl_ff;
  logic at_empty;
  logic at_full;
  logic do_push;
  logic do_pop;
  logic [4:0] sp_up;
  logic [20:0] tos;
  logic set_full;
  logic set_unf;
  logic wr_ptr;
  logic wr_tos;
  logic [1:0] tos_lane;

  assign at_empty = (sp_ff == SP_EMPTY);
  assign at_full = (sp_ff == SP_FULL);
  // interrupt acknowledge and wake both push like a call
  assign do_push = i_push | i_irq_ack;
  // a push in the same cycle wins; the sequencer never issues both
  assign do_pop = i_pop & ~do_push;
  assign sp_up = sp_ff + 5'h01;
  assign tos = at_empty ? 21'h000000 : stack_ff[sp_ff];
  assign set_full = do_push & (sp_ff >= SP_LAST_FREE);
  assign set_unf = do_pop & at_empty;
  assign wr_ptr = i_reg_wr & (i_reg_addr == REG_RETURN_STACK_POINTER);
  assign wr_tos = i_reg_wr & (i_reg_addr == REG_STACK_TOP_LOW ||
    i_reg_addr == REG_STACK_TOP_HIGH || i_reg_addr == REG_STACK_TOP_UPPER);
  assign tos_lane = i_reg_addr[1:0];

  // ----------------------------------------------------------------
  // stack pointer
  // ----------------------------------------------------------------
  // a push or pop that moves the pointer beats a software pointer write in the same cycle
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
      sp_ff <= SP_EMPTY;
    else if (do_push && !at_full)
      sp_ff <= sp_up;
    else if (do_pop && !at_empty)
      sp_ff <= sp_ff - 5'h01;
    else if (wr_ptr)
      sp_ff <= i_reg_wdata[4:0];
  end

  // ----------------------------------------------------------------
  // stack storage
  // ----------------------------------------------------------------
  // a push never overwrites entry 31 once the stack is full
  always_ff @(posedge i_core_clk)
  begin
    if (do_push && !at_full)
      stack_ff[sp_up] <= i_pc;
    else if (wr_tos && !at_empty && !do_pop)
      stack_ff[sp_ff] <= merge_byte(stack_ff[sp_ff], tos_lane, i_reg_wdata);
  end

  // ----------------------------------------------------------------
  // full and underflow flags
  // ----------------------------------------------------------------
  // of the resets only power-on clears them; set beats a software clear
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      if (i_por)
      begin
        full_ff <= 1'b0;
        unf_ff <= 1'b0;
      end
    end
    else
    begin
      if (set_full)
        full_ff <= 1'b1;
      else if (wr_ptr && !i_reg_wdata[PTR_FULL_BIT])
        full_ff <= 1'b0;
      if (set_unf)
        unf_ff <= 1'b1;
      else if (wr_ptr && !i_reg_wdata[PTR_UNDERFLOW_BIT])
        unf_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // fault reset request
  // ----------------------------------------------------------------
  // the system turns this pulse into a non-power-on reset, so the
  // pointer returns to zero while the flags survive
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
      o_stack_fault_reset <= 1'b0;
    else
      o_stack_fault_reset <= cfg_fault_rst_ff & (set_full | set_unf);
  end

  // ----------------------------------------------------------------
  // program counter load
  // ----------------------------------------------------------------
  logic boot_pending_ff;

  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
      boot_pending_ff <= 1'b1;
    else
      boot_pending_ff <= 1'b0;
  end

  // the counter latch registers live outside and are never driven here
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      o_pc_load <= 1'b0;
      o_pc_target <= RESET_VECTOR;
    end
    else if (boot_pending_ff)
    begin
      o_pc_load <= 1'b1;
      o_pc_target <= RESET_VECTOR;
    end
    else if (i_irq_ack)
    begin
      o_pc_load <= 1'b1;
      o_pc_target <= i_irq_high ? IRQ_HIGH_VECTOR : IRQ_LOW_VECTOR;
    end
    else if (do_pop)
    begin
      o_pc_load <= 1'b1;
      o_pc_target <= tos;
    end
    else
    begin
      o_pc_load <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // memory bus control register
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
      memctl_ff <= MEMCTL_RESET;
    else if (i_reg_wr && i_reg_addr == REG_MEMORY_BUS_CONTROL)
      memctl_ff <= i_reg_wdata;
  end

  // waits apply only when the config bit leaves them enabled
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
      o_wait_count <= NO_WAIT;
    else
      o_wait_count <= cfg_wait_dis_ff ? NO_WAIT :
        memctl_ff[WAIT_COUNT_LSB +: 2];
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  // data stands in the cycle after the strobe only
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset || !i_reg_rd)
      o_reg_rdata <= 8'h00;
    else
    begin
      case (i_reg_addr)
        REG_STACK_TOP_LOW: o_reg_rdata <= tos[7:0];
        REG_STACK_TOP_HIGH: o_reg_rdata <= tos[15:8];
        REG_STACK_TOP_UPPER: o_reg_rdata <= {3'b000, tos[20:16]};
        REG_RETURN_STACK_POINTER: o_reg_rdata <= {full_ff, unf_ff, 1'b0, sp_ff};
        REG_MEMORY_BUS_CONTROL: o_reg_rdata <= memctl_ff;
        REG_PROGRAM_SPACE_CONFIG: o_reg_rdata <= {cfg_wait_dis_ff, 5'h00, eff_mode};
        default: o_reg_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // program space routing
  // ----------------------------------------------------------------
  // data RAM and EEPROM sit on their own bus and see no mode gating
  logic map_int;
  logic map_ext;
  logic map_zero;
  logic route_ext_ff;
  logic route_zero_ff;
  logic route_valid_ff;

  psmrs_addr_map u_map (
    .i_mode(eff_mode),
    .i_addr(i_acc_addr),
    .i_flash_top(FLASH_TOP),
    .i_boot_top(BOOT_TOP),
    .o_to_int(map_int),
    .o_to_ext(map_ext),
    .o_zero_fill(map_zero)
  );

  // fetch, table read and table write share one decode
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      o_int_req <= 1'b0;
      o_ext_req <= 1'b0;
      o_mem_write <= 1'b0;
      o_mem_addr <= RESET_VECTOR;
      route_ext_ff <= 1'b0;
      route_zero_ff <= 1'b0;
      route_valid_ff <= 1'b0;
    end
    else
    begin
      o_int_req <= i_acc_req & map_int;
      o_ext_req <= i_acc_req & map_ext & HAS_EXT_BUS;
      o_mem_write <= i_acc_req & i_acc_write & ~map_zero;
      if (i_acc_req)
        o_mem_addr <= i_acc_addr;
      route_ext_ff <= map_ext;
      route_zero_ff <= map_zero;
      route_valid_ff <= i_acc_req & ~i_acc_write;
    end
  end

  // unimplemented space reads as zero, a no-operation word
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      o_rdata_valid <= 1'b0;
      o_rdata <= 16'h0000;
    end
    else
    begin
      o_rdata_valid <= route_valid_ff;
      if (route_zero_ff)
        o_rdata <= 16'h0000;
      else if (route_ext_ff)
        o_rdata <= i_ext_rdata;
      else
        o_rdata <= i_int_rdata;
    end
  end

  // software edits of the top entry rely on interrupts being masked
  // by the caller; a push arriving mid-edit would still win

endmodule
`default_nettype wire

// ===== design/psmrs_pkg.sv
// constants for the program space map and return stack block
// assumes a single core clock and a byte-wide register port
package psmrs_pkg;

  // ----------------------------------------------------------------
  // widths and stack geometry
  // ----------------------------------------------------------------
  localparam int PC_W = 21;
  localparam int SP_W = 5;
  localparam int STACK_DEPTH = 31;
  localparam logic [4:0] SP_EMPTY = 5'h00;
  localparam logic [4:0] SP_FULL = 5'h1f;
  localparam logic [4:0] SP_LAST_FREE = 5'h1e;

  // ----------------------------------------------------------------
  // program space addresses
  // ----------------------------------------------------------------
  localparam logic [20:0] RESET_VECTOR = 21'h000000;
  localparam logic [20:0] IRQ_HIGH_VECTOR = 21'h000008;
  localparam logic [20:0] IRQ_LOW_VECTOR = 21'h000018;
  localparam logic [20:0] FLASH_TOP_32K = 21'h007fff;
  localparam logic [20:0] FLASH_TOP_64K = 21'h00ffff;
  localparam logic [20:0] FLASH_TOP_128K = 21'h01ffff;
  localparam logic [20:0] BOOT_TOP_SMALL = 21'h0007ff;
  localparam logic [20:0] BOOT_TOP_LARGE = 21'h0001ff;

  // ----------------------------------------------------------------
  // memory mode codes, two low bits of the config byte
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PSMRS_EXTENDED_MIXED_MODE = 2'b00,
    PSMRS_BOOT_BLOCK_EXTERNAL_MODE = 2'b01,
    PSMRS_EXTERNAL_ONLY_MODE = 2'b10,
    PSMRS_INTERNAL_ONLY_MODE = 2'b11
  } psmrs_mode_e;

  // ----------------------------------------------------------------
  // register offsets and fields
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_STACK_TOP_LOW = 4'h0;
  localparam logic [3:0] REG_STACK_TOP_HIGH = 4'h1;
  localparam logic [3:0] REG_STACK_TOP_UPPER = 4'h2;
  localparam logic [3:0] REG_RETURN_STACK_POINTER = 4'h3;
  localparam logic [3:0] REG_MEMORY_BUS_CONTROL = 4'h4;
  localparam logic [3:0] REG_PROGRAM_SPACE_CONFIG = 4'h5;
  localparam int CFG_WAIT_DISABLE_BIT = 7;
  localparam int PTR_FULL_BIT = 7;
  localparam int PTR_UNDERFLOW_BIT = 6;
  localparam int WAIT_COUNT_LSB = 4;
  localparam logic [7:0] MEMCTL_RESET = 8'h00;
  localparam logic [1:0] NO_WAIT = 2'h0;

endpackage
